// ---- common/frac_pll_cfg.svh ----
`ifndef FRAC_PLL_CFG_SVH
`define FRAC_PLL_CFG_SVH

// Register offsets on the programming port.
`define N_DIV_HIGH_OFF 8'h22
`define N_DIV_LOW_OFF 8'h24
`define PD_DELAY_CFG_OFF 8'h25
`define DEN_HIGH_OFF 8'h26
`define DEN_LOW_OFF 8'h27
`define SEED_HIGH_OFF 8'h28
`define SEED_LOW_OFF 8'h29
`define NUM_HIGH_OFF 8'h2a
`define NUM_LOW_OFF 8'h2b
`define MOD_CTRL_OFF 8'h2c
`define ENGINE_STATUS_OFF 8'h7f

// Reset values.
`define N_DIV_HIGH_RST 16'h0010
`define N_DIV_LOW_RST 16'h0070
`define PD_DELAY_CFG_RST 16'h0205
`define DEN_HIGH_RST 16'hffff
`define DEN_LOW_RST 16'hffff
`define SEED_HIGH_RST 16'h0000
`define SEED_LOW_RST 16'h0000
`define NUM_HIGH_RST 16'h0000
`define NUM_LOW_RST 16'h0000
`define MOD_CTRL_RST 16'h22a2

// Field positions.
`define PD_DELAY_MSB 13
`define PD_DELAY_LSB 8
`define N_DIV_HIGH_MSB 2
`define MOD_RESET_LOW_BIT 5
`define MOD_ORDER_MSB 2
`define MOD_ORDER_LSB 0

// Modulator order codes.
`define ORDER_INTEGER 3'h0
`define ORDER_FIRST 3'h1
`define ORDER_SECOND 3'h2
`define ORDER_THIRD 3'h3

// Modulator step timing: one step per phase detector period.
`define CLK_SYS_MHZ 50
`define REF_STEP_NS 100
`define REF_STEP_CYCLES ((`REF_STEP_NS * `CLK_SYS_MHZ) / 1000)

`endif

// ---- common/frac_pll_pkg.sv ----
package frac_pll_pkg;
    typedef logic [7:0] reg_addr_t;
    typedef logic [15:0] reg_word_t;
    typedef logic [31:0] frac_word_t;
    typedef logic [18:0] n_div_t;
    typedef enum {ENG_HELD, ENG_LOAD, ENG_RUN} engine_state_t;
endpackage : frac_pll_pkg

// ---- hdl/ref_step_divider.sv ----
`timescale 1ns/1ns
`include "frac_pll_cfg.svh"

module ref_step_divider (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Step enable out.
    output logic step
);
    import frac_pll_pkg::*;

    localparam logic [7:0] LAST_COUNT = 8'(`REF_STEP_CYCLES - 1);

    logic [7:0] count_ff;

    // Free running divider; the step pulse is one cycle wide.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= 8'h00;
            step <= 1'b0;
        end else if (count_ff == LAST_COUNT) begin
            count_ff <= 8'h00;
            step <= 1'b1;
        end else begin
            count_ff <= count_ff + 8'h01;
            step <= 1'b0;
        end
    end
endmodule : ref_step_divider

// ---- hdl/mod_accumulator.sv ----
`timescale 1ns/1ns

module mod_accumulator (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control.
    input wire logic load,
    input wire logic step,
    input wire frac_pll_pkg::frac_word_t load_value,
    input wire frac_pll_pkg::frac_word_t addend,
    input wire frac_pll_pkg::frac_word_t modulus,
    // Result.
    output logic carry,
    output frac_pll_pkg::frac_word_t residue
);
    import frac_pll_pkg::*;

    logic [32:0] sum;
    logic wrap;

    // Sum is one bit wider so that a wrap past 2^32 is still seen.
    always_comb begin
        sum = {1'b0, residue} + {1'b0, addend};
        wrap = (sum >= {1'b0, modulus});
    end

    // A zero modulus wraps every step; software must not leave it there.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            residue <= 32'h0000_0000;
            carry <= 1'b0;
        end else if (load) begin
            residue <= load_value;
            carry <= 1'b0;
        end else if (step) begin
            residue <= wrap ? 32'(sum - {1'b0, modulus}) : sum[31:0];
            carry <= wrap;
        end
    end
endmodule : mod_accumulator

// ---- hdl/fractional_pll_config_regs.sv ----
// What this block does
// - Six-bit delay select, bits 13-8, reset 0x2.
// - Denominator high half at 0x26, reset 0xFFFF.
// - Denominator low half at 0x27, reset 0xFFFF.
// - Seed high half at 0x28, reset zero.
// - Seed low half at 0x29, reset zero.
// - Seed loads engine state whenever it starts.
// - Numerator high half at 0x2A, reset zero.
// - Numerator low half at 0x2B, reset zero.
// - Integer divider is 19 bits, 3+16 split.
// - Order codes: integer, first, second, third.
// - Active-low modulator reset holds engine, default one.
`timescale 1ns/1ns
`include "frac_pll_cfg.svh"

module fractional_pll_config_regs (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port.
    input wire frac_pll_pkg::reg_addr_t reg_addr,
    input wire frac_pll_pkg::reg_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output frac_pll_pkg::reg_word_t reg_rdata,
    // Feedback path.
    output logic [5:0] phase_detector_delay_select,
    output frac_pll_pkg::n_div_t feedback_divide,
    output logic feedback_divide_valid,
    output logic modulator_running
);
    import frac_pll_pkg::*;

    // Register storage.
    reg_word_t n_div_high_ff;
    reg_word_t n_div_low_ff;
    reg_word_t phase_detector_delay_config_ff;
    reg_word_t fraction_denominator_high_ff;
    reg_word_t fraction_denominator_low_ff;
    reg_word_t modulator_seed_high_ff;
    reg_word_t modulator_seed_low_ff;
    reg_word_t fraction_numerator_high_ff;
    reg_word_t fraction_numerator_low_ff;
    reg_word_t modulator_control_ff;

    // Derived values.
    frac_word_t fraction_denominator;
    frac_word_t fraction_numerator;
    frac_word_t modulator_seed;
    n_div_t n_divide;
    logic [2:0] modulator_order;
    logic modulator_reset_low;

    // Engine.
    engine_state_t state_ff;
    engine_state_t nxt_state;
    logic step;
    logic step_d_ff;
    logic engine_load;
    logic engine_step;
    logic [2:0] carry;
    frac_word_t residue [3];
    frac_word_t stage_addend [3];
    frac_word_t stage_load [3];
    logic c2_z_ff;
    logic c3_z_ff;
    logic c3_zz_ff;
    logic signed [3:0] offset;
    logic signed [3:0] last_offset_ff;
    logic signed [20:0] divide_sum;

    // Write decode, one strobe per register.
    logic wr_n_high;
    logic wr_n_low;
    logic wr_delay;
    logic wr_den_high;
    logic wr_den_low;
    logic wr_seed_high;
    logic wr_seed_low;
    logic wr_num_high;
    logic wr_num_low;
    logic wr_ctrl;

    assign wr_n_high = reg_wr && (reg_addr == `N_DIV_HIGH_OFF);
    assign wr_n_low = reg_wr && (reg_addr == `N_DIV_LOW_OFF);
    assign wr_delay = reg_wr && (reg_addr == `PD_DELAY_CFG_OFF);
    assign wr_den_high = reg_wr && (reg_addr == `DEN_HIGH_OFF);
    assign wr_den_low = reg_wr && (reg_addr == `DEN_LOW_OFF);
    assign wr_seed_high = reg_wr && (reg_addr == `SEED_HIGH_OFF);
    assign wr_seed_low = reg_wr && (reg_addr == `SEED_LOW_OFF);
    assign wr_num_high = reg_wr && (reg_addr == `NUM_HIGH_OFF);
    assign wr_num_low = reg_wr && (reg_addr == `NUM_LOW_OFF);
    assign wr_ctrl = reg_wr && (reg_addr == `MOD_CTRL_OFF);

    // Integer divider upper part.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            n_div_high_ff <= `N_DIV_HIGH_RST;
        end else if (wr_n_high) begin
            n_div_high_ff <= reg_wdata;
        end
    end

    // Integer divider lower part.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            n_div_low_ff <= `N_DIV_LOW_RST;
        end else if (wr_n_low) begin
            n_div_low_ff <= reg_wdata;
        end
    end

    // Delay configuration. Reserved fields keep whatever the host writes, so the
    // values the host must program there are read back unchanged.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_detector_delay_config_ff <= `PD_DELAY_CFG_RST;
        end else if (wr_delay) begin
            phase_detector_delay_config_ff <= reg_wdata;
        end
    end

    // Denominator upper half.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fraction_denominator_high_ff <= `DEN_HIGH_RST;
        end else if (wr_den_high) begin
            fraction_denominator_high_ff <= reg_wdata;
        end
    end

    // Denominator lower half.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fraction_denominator_low_ff <= `DEN_LOW_RST;
        end else if (wr_den_low) begin
            fraction_denominator_low_ff <= reg_wdata;
        end
    end

    // Seed upper half.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            modulator_seed_high_ff <= `SEED_HIGH_RST;
        end else if (wr_seed_high) begin
            modulator_seed_high_ff <= reg_wdata;
        end
    end

    // Seed lower half.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            modulator_seed_low_ff <= `SEED_LOW_RST;
        end else if (wr_seed_low) begin
            modulator_seed_low_ff <= reg_wdata;
        end
    end

    // Numerator upper half.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fraction_numerator_high_ff <= `NUM_HIGH_RST;
        end else if (wr_num_high) begin
            fraction_numerator_high_ff <= reg_wdata;
        end
    end

    // Numerator lower half.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fraction_numerator_low_ff <= `NUM_LOW_RST;
        end else if (wr_num_low) begin
            fraction_numerator_low_ff <= reg_wdata;
        end
    end

    // Modulator control word.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            modulator_control_ff <= `MOD_CTRL_RST;
        end else if (wr_ctrl) begin
            modulator_control_ff <= reg_wdata;
        end
    end

    // Pairs are joined live, so a half written alone takes effect at once; the
    // host should update both halves while the engine is held if that matters.
    assign fraction_denominator = {fraction_denominator_high_ff,
                                   fraction_denominator_low_ff};
    assign fraction_numerator = {fraction_numerator_high_ff,
                                 fraction_numerator_low_ff};
    assign modulator_seed = {modulator_seed_high_ff, modulator_seed_low_ff};
    assign n_divide = {n_div_high_ff[`N_DIV_HIGH_MSB:0], n_div_low_ff};
    assign modulator_order = modulator_control_ff[`MOD_ORDER_MSB:`MOD_ORDER_LSB];
    assign modulator_reset_low = modulator_control_ff[`MOD_RESET_LOW_BIT];

    // Delay select leaves the block registered.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_detector_delay_select <= 6'h02;
        end else begin
            phase_detector_delay_select <=
                phase_detector_delay_config_ff[`PD_DELAY_MSB:`PD_DELAY_LSB];
        end
    end

    // Read port: data stand only in the cycle after the strobe.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `N_DIV_HIGH_OFF: reg_rdata <= n_div_high_ff;
                `N_DIV_LOW_OFF: reg_rdata <= n_div_low_ff;
                `PD_DELAY_CFG_OFF: reg_rdata <= phase_detector_delay_config_ff;
                `DEN_HIGH_OFF: reg_rdata <= fraction_denominator_high_ff;
                `DEN_LOW_OFF: reg_rdata <= fraction_denominator_low_ff;
                `SEED_HIGH_OFF: reg_rdata <= modulator_seed_high_ff;
                `SEED_LOW_OFF: reg_rdata <= modulator_seed_low_ff;
                `NUM_HIGH_OFF: reg_rdata <= fraction_numerator_high_ff;
                `NUM_LOW_OFF: reg_rdata <= fraction_numerator_low_ff;
                `MOD_CTRL_OFF: reg_rdata <= modulator_control_ff;
                `ENGINE_STATUS_OFF: reg_rdata <= {8'h00, last_offset_ff, 3'h0,
                                                  modulator_running};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Phase detector rate steps for the engine.
    ref_step_divider u_step (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .step(step)
    );

    // Engine sequencing: held, one load cycle, then running.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ENG_HELD: begin
                if (modulator_reset_low) begin
                    nxt_state = ENG_LOAD;
                end
            end
            ENG_LOAD: begin
                nxt_state = modulator_reset_low ? ENG_RUN : ENG_HELD;
            end
            ENG_RUN: begin
                if (!modulator_reset_low) begin
                    nxt_state = ENG_HELD;
                end
            end
            default: nxt_state = ENG_HELD;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ENG_HELD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Loading happens while held as well, so a released engine always starts
    // from the seed even if the seed changed during the hold.
    assign engine_load = (state_ff != ENG_RUN);
    assign engine_step = (state_ff == ENG_RUN) && step;

    // Three cascaded accumulators; each stage feeds its residue to the next.
    for (genvar g = 0; g < 3; g++) begin : g_stage
        if (g == 0) begin : g_first
            assign stage_addend[g] = fraction_numerator;
            assign stage_load[g] = modulator_seed;
        end else begin : g_next
            assign stage_addend[g] = residue[g - 1];
            assign stage_load[g] = 32'h0000_0000;
        end
        mod_accumulator u_acc (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .load(engine_load),
            .step(engine_step),
            .load_value(stage_load[g]),
            .addend(stage_addend[g]),
            .modulus(fraction_denominator),
            .carry(carry[g]),
            .residue(residue[g])
        );
    end

    // Delayed carries for the noise shaping differences.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            c2_z_ff <= 1'b0;
            c3_z_ff <= 1'b0;
            c3_zz_ff <= 1'b0;
        end else if (engine_load) begin
            c2_z_ff <= 1'b0;
            c3_z_ff <= 1'b0;
            c3_zz_ff <= 1'b0;
        end else if (step_d_ff) begin
            c2_z_ff <= carry[1];
            c3_z_ff <= carry[2];
            c3_zz_ff <= c3_z_ff;
        end
    end

    // The carries settle one cycle after a step, so the combiner runs then.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            step_d_ff <= 1'b0;
        end else begin
            step_d_ff <= engine_step;
        end
    end

    // Combine stages by order; unused codes fall back to integer mode.
    always_comb begin
        offset = 4'sh0;
        case (modulator_order)
            `ORDER_INTEGER: offset = 4'sh0;
            `ORDER_FIRST: offset = $signed({3'h0, carry[0]});
            `ORDER_SECOND: begin
                offset = $signed({3'h0, carry[0]}) + $signed({3'h0, carry[1]})
                         - $signed({3'h0, c2_z_ff});
            end
            `ORDER_THIRD: begin
                offset = $signed({3'h0, carry[0]}) + $signed({3'h0, carry[1]})
                         - $signed({3'h0, c2_z_ff}) + $signed({3'h0, carry[2]})
                         - $signed({2'h0, c3_z_ff, 1'b0})
                         + $signed({3'h0, c3_zz_ff});
            end
            default: offset = 4'sh0;
        endcase
    end

    // In first, second and third order, averaged over many steps the offset equals numerator over denominator.
    assign divide_sum = $signed({2'h0, n_divide}) + 21'(offset);

    // Instantaneous divide value, one update per engine step.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            feedback_divide <= 19'h0_0070;
            feedback_divide_valid <= 1'b0;
            last_offset_ff <= 4'sh0;
        end else if (step_d_ff) begin
            feedback_divide <= divide_sum[18:0];
            feedback_divide_valid <= 1'b1;
            last_offset_ff <= offset;
        end else begin
            feedback_divide_valid <= 1'b0;
        end
    end

    // Running flag for status and the output port.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            modulator_running <= 1'b0;
        end else begin
            modulator_running <= (nxt_state == ENG_RUN);
        end
    end
endmodule : fractional_pll_config_regs

// ---- tb/fractional_pll_config_regs_chk.sv ----
`timescale 1ns/1ns

module fractional_pll_config_regs_chk (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port.
    input wire frac_pll_pkg::reg_addr_t reg_addr,
    input wire frac_pll_pkg::reg_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire frac_pll_pkg::reg_word_t reg_rdata,
    // Feedback path.
    input wire logic [5:0] phase_detector_delay_select,
    input wire frac_pll_pkg::n_div_t feedback_divide,
    input wire logic feedback_divide_valid,
    input wire logic modulator_running
);
    import frac_pll_pkg::*;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Delay field as a plain net, so that $past sees a whole signal.
    logic [5:0] wr_delay;
    assign wr_delay = reg_wdata[13:8];

    // Read data are zero outside the cycle after a read strobe.
    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not cleared outside read cycle");
    // The delay select output trails a write by two edges.
    AST_DELAY_OUT: assert property (reg_wr && reg_addr == 8'h25 |-> ##2
        phase_detector_delay_select == $past(wr_delay, 2))
        else $error("delay select does not follow the written field");
    // Each half of a 32-bit value reads back what was written to it.
    AST_DEN_RB: assert property (reg_wr && reg_addr inside {8'h26, 8'h27}
        ##1 !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2)
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("denominator read back wrong");
    AST_SEED_RB: assert property (reg_wr && reg_addr inside {8'h28, 8'h29}
        ##1 !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2)
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("seed read back wrong");
    AST_NUM_RB: assert property (reg_wr && reg_addr inside {8'h2a, 8'h2b}
        ##1 !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2)
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("numerator read back wrong");
    // One engine step per five clocks, so valid pulses stand apart.
    AST_VALID_GAP: assert property (feedback_divide_valid |=>
        !feedback_divide_valid [*4])
        else $error("feedback valid pulses too close");
    AST_FB_ON_VALID: assert property ($changed(feedback_divide) |->
        feedback_divide_valid)
        else $error("feedback divide changed without valid");
    // A held engine produces no new divide values.
    AST_HELD_QUIET: assert property (!modulator_running [*3] |->
        !feedback_divide_valid)
        else $error("divide update while engine held");
    AST_RUN_START: assert property (reg_wr && reg_addr == 8'h2c && reg_wdata[5]
        && !modulator_running |-> ##[1:3] modulator_running)
        else $error("engine did not start after release");
endmodule : fractional_pll_config_regs_chk

bind fractional_pll_config_regs fractional_pll_config_regs_chk chk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .phase_detector_delay_select(phase_detector_delay_select),
    .feedback_divide(feedback_divide),
    .feedback_divide_valid(feedback_divide_valid),
    .modulator_running(modulator_running)
);

// ---- tb/pll_host_model.sv ----
`timescale 1ns/1ns
`include "frac_pll_cfg.svh"

module pll_host_model (
    // Clock.
    input wire logic clk_sys,
    // Register port.
    output frac_pll_pkg::reg_addr_t reg_addr,
    output frac_pll_pkg::reg_word_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire frac_pll_pkg::reg_word_t reg_rdata
);
    import frac_pll_pkg::*;

    // Strobes idle low from time zero so reset never sees a stray request.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Data are inverted after a write, so a stale word never looks current.
    task automatic wr_reg(input reg_addr_t addr, input reg_word_t data);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~data;
    endtask : wr_reg

    task automatic rd_reg(input reg_addr_t addr, output reg_word_t data);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask : rd_reg

    // Reserved fields get their required patterns, not their reset values.
    task automatic set_delay(input logic [5:0] sel);
        wr_reg(`PD_DELAY_CFG_OFF, {2'h2, sel, 8'h04});
    endtask : set_delay

    // A nonzero seed is how the host shifts output phase.
    task automatic set_frac(input frac_word_t den, input frac_word_t num, input frac_word_t sd);
        wr_reg(`DEN_HIGH_OFF, den[31:16]);
        wr_reg(`DEN_LOW_OFF, den[15:0]);
        wr_reg(`NUM_HIGH_OFF, num[31:16]);
        wr_reg(`NUM_LOW_OFF, num[15:0]);
        wr_reg(`SEED_HIGH_OFF, sd[31:16]);
        wr_reg(`SEED_LOW_OFF, sd[15:0]);
    endtask : set_frac

    task automatic set_ctrl(input logic run, input logic [2:0] ord);
        wr_reg(`MOD_CTRL_OFF, {8'h22, 2'h2, run, 2'h0, ord});
    endtask : set_ctrl
endmodule : pll_host_model

// ---- tb/test_fractional_pll_config_regs.sv ----
`timescale 1ns/1ns
`include "frac_pll_cfg.svh"

module test_fractional_pll_config_regs;
    import frac_pll_pkg::*;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    reg_addr_t reg_addr;
    reg_word_t reg_wdata;
    logic reg_wr;
    logic reg_rd;
    reg_word_t reg_rdata;
    logic [5:0] phase_detector_delay_select;
    n_div_t feedback_divide;
    logic feedback_divide_valid;
    logic modulator_running;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    reg_addr_t addrs [7] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b};
    reg_word_t rst_vals [7] = '{16'h0205, 16'hffff, 16'hffff, 16'h0000, 16'h0000,
        16'h0000, 16'h0000};

    // Free-running 50 MHz clock.
    always #10 clk_sys = ~clk_sys;

    pll_host_model host (
        .clk_sys(clk_sys),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );

    fractional_pll_config_regs uut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .phase_detector_delay_select(phase_detector_delay_select),
        .feedback_divide(feedback_divide),
        .feedback_divide_valid(feedback_divide_valid),
        .modulator_running(modulator_running)
    );

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    // A hang is cut short well beyond the longest expected run.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            finish_test();
        end
    end

    // Waits for the next divide update; a missing pulse counts as a mismatch.
    task automatic wait_valid(output n_div_t fb);
        int k;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_sys);
            #1;
            if (feedback_divide_valid === 1'b1) break;
        end
        check("divide valid", 32'h0000_0001, {31'h0, feedback_divide_valid});
        fb = feedback_divide;
    endtask : wait_valid

    task automatic t_reset_values();
        reg_word_t d;
        check("delay select", 32'h0000_0002, {26'h0, phase_detector_delay_select});
        for (int i = 0; i < 7; i++) begin
            host.rd_reg(addrs[i], d);
            check("reset value", {16'h0, rst_vals[i]}, {16'h0, d});
        end
        host.rd_reg(8'h30, d);
        check("unmapped read", 32'h0000_0000, {16'h0, d});
    endtask : t_reset_values

    task automatic t_readback();
        reg_word_t d;
        reg_word_t v;
        for (int i = 0; i < 7; i++) begin
            // The delay register still gets its required reserved patterns.
            v = (i == 0) ? {2'h2, 6'h1a, 8'h04} : 16'ha5c3 ^ {8'h00, addrs[i]};
            host.wr_reg(addrs[i], v);
            host.rd_reg(addrs[i], d);
            check("read back", {16'h0, v}, {16'h0, d});
        end
        host.wr_reg(8'h30, 16'hbeef);
        host.rd_reg(8'h30, d);
        check("unmapped write", 32'h0000_0000, {16'h0, d});
        host.set_delay(6'h2d);
        repeat (2) @(posedge clk_sys);
        #1;
        check("delay select", 32'h0000_002d, {26'h0, phase_detector_delay_select});
        host.rd_reg(`PD_DELAY_CFG_OFF, d);
        check("delay register", 32'h0000_ad04, {16'h0, d});
    endtask : t_readback

    // The seed decides where the first carry falls after the engine starts.
    task automatic t_seed(input frac_word_t sd, input n_div_t exp);
        n_div_t fb;
        host.set_frac(32'h0000_0010, 32'h0000_0001, sd);
        host.set_ctrl(1'b0, 3'h1);
        host.set_ctrl(1'b1, 3'h1);
        wait_valid(fb);
        check("first divide", {13'h0, exp}, {13'h0, fb});
    endtask : t_seed

    // Over 32 steps a quarter ratio gives eight carries; higher orders wander a little.
    // Code four is unused and must behave as integer mode.
    task automatic t_orders();
        n_div_t fb;
        int sum;
        int tol;
        int want;
        host.set_frac(32'h0000_0004, 32'h0000_0001, 32'h0000_0000);
        for (int ord = 0; ord < 5; ord++) begin
            host.set_ctrl(1'b0, ord[2:0]);
            host.set_ctrl(1'b1, ord[2:0]);
            sum = 0;
            tol = (ord == 2 || ord == 3) ? 4 : 0;
            want = (ord inside {[1:3]}) ? 8 : 0;
            repeat (32) begin
                wait_valid(fb);
                sum += int'(fb) - 'h70;
            end
            n_compared++;
            if (sum < want - tol || sum > want + tol) begin
                n_fail++;
                $display("Error offset sum order %0d expected %0d seen %0d", ord, want, sum);
            end
        end
        host.set_ctrl(1'b0, 3'h2);
        repeat (10) @(posedge clk_sys);
        #1;
        check("engine held", 32'h0000_0000, {31'h0, modulator_running});
    endtask : t_orders

    task automatic t_ndiv();
        n_div_t fb;
        reg_word_t d;
        host.wr_reg(`N_DIV_HIGH_OFF, 16'h0005);
        host.wr_reg(`N_DIV_LOW_OFF, 16'h0001);
        host.set_ctrl(1'b0, 3'h0);
        host.set_ctrl(1'b1, 3'h0);
        wait_valid(fb);
        check("integer divide", 32'h0005_0001, {13'h0, fb});
        // Integer mode leaves a zero offset, and the engine reports itself running.
        host.rd_reg(`ENGINE_STATUS_OFF, d);
        check("engine status", 32'h0000_0001, {16'h0, d});
    endtask : t_ndiv

    // Main sequence: reset, register checks, then engine behaviour.
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset_values();
        t_readback();
        t_seed(32'h0000_000f, 19'h0_0071);
        t_seed(32'h0000_0000, 19'h0_0070);
        t_orders();
        t_ndiv();
        finish_test();
    end
endmodule : test_fractional_pll_config_regs
